// ==== include/urx_pkg.sv ====
package urx_pkg;

  // apb side
  localparam int          ADDR_W = 12;
  localparam int          DATA_W = 32;
  localparam int          BYTE_W = 8;

  // register indexes; byte address is four times the index
  localparam logic [7:0]  IDX_POWER_CTRL   = 8'h87;
  localparam logic [7:0]  IDX_SERIAL_CTRL  = 8'h98;
  localparam logic [7:0]  IDX_SERIAL_BUF   = 8'h99;
  localparam logic [7:0]  IDX_STATION_ADDR = 8'hA9;
  localparam logic [7:0]  IDX_STATION_MASK = 8'hB9;
  localparam logic [7:0]  IDX_RX_BAUD      = 8'hC0;
  localparam logic [7:0]  IDX_TX_BAUD      = 8'hC1;
  localparam logic [7:0]  IDX_IRQ_STATUS   = 8'hC2;
  localparam logic [7:0]  IDX_IRQ_MASK     = 8'hC3;

  // serial control register fields
  localparam int          SC_ERR_MODE0 = 7;
  localparam int          SC_MODE1     = 6;
  localparam int          SC_MPE       = 5;
  localparam int          SC_RX_EN     = 4;
  localparam int          SC_TX_NINTH  = 3;
  localparam int          SC_RX_NINTH  = 2;
  localparam int          SC_TX_DONE   = 1;
  localparam int          SC_RX_DONE   = 0;
  // power control register field
  localparam int          PC_FCE       = 6;

  // interrupt status and mask layout
  localparam int          EV_W     = 3;
  localparam int          EV_RX    = 0;
  localparam int          EV_TX    = 1;
  localparam int          EV_FRAME = 2;

  // reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [7:0]  RST_BAUD = 8'h0F;

  // bit timing: sixteen baud ticks per bit, sample in the middle
  localparam logic [3:0]  SUB_MID  = 4'h7;
  localparam logic [3:0]  SUB_LAST = 4'hF;
  localparam logic [3:0]  BITS_8   = 4'h8;
  localparam logic [3:0]  BITS_9   = 4'h9;
  localparam int          NINTH    = 8;

  // serial modes as {mode bit 0, mode bit 1}
  localparam logic [1:0]  MODE0 = 2'b00;
  localparam logic [1:0]  MODE1 = 2'b01;

  typedef enum logic [1:0] {
    RX_IDLE, RX_START, RX_DATA, RX_STOP
  } urx_rx_e;

  typedef enum logic [1:0] {
    TX_IDLE, TX_START, TX_DATA, TX_STOP
  } urx_tx_e;

endpackage : urx_pkg

// ==== design/urx_baud_tick.sv ====
`timescale 1ns/1ps
module urx_baud_tick
  import urx_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        restart,
  input  wire logic [7:0]  divisor,
  output logic             tick
);

  logic [7:0] count;

  // one tick every divisor+1 clocks; restart aligns ticks to a frame edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= RST_BYTE;
    end else if (restart || count == divisor) begin
      count <= RST_BYTE;
    end else begin
      count <= count + 8'h01;
    end
  end

  assign tick = !restart && count == divisor;

endmodule : urx_baud_tick

// ==== design/urx_serial_port.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - framing check in modes 1-3 when enabled
// - invalid stop bit sets frame error flag
// - frame error flag sticky until software or reset
// - with framing check, receive done at stop
// - address recognition active when multiprocessor enable set
// - address frames raise receive done only on match
// - mode 1: stop bit is ninth, must be valid
// - multiprocessor enable ignored in mode 0
// - given address: station address, zero mask bits ignored
// - broadcast is address OR mask, zeros ignored
// - accept given or broadcast address match
// - reset clears station address and mask
// - receive and transmit run with independent baud rates
// - bit 7 is frame error or mode bit 0
// - multiprocessor reception in modes 1, 2, 3
module urx_serial_port
  import urx_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              rxd,
  output logic                   txd,
  output logic                   irq
);

  function automatic logic [ADDR_W-1:0] addr_of(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : addr_of

  // masked compare, zero mask bits are don't-care
  function automatic logic addr_eq(input logic [7:0] rx,
                                   input logic [7:0] adr,
                                   input logic [7:0] msk);
    return ((rx ^ adr) & msk) == RST_BYTE;
  endfunction : addr_eq

  logic             serial_mode_bit0;
  logic             serial_mode_bit1;
  logic             multiprocessor_enable;
  logic             rx_enable;
  logic             tx_ninth;
  logic             received_ninth_bit;
  logic             transmit_done_flag;
  logic             receive_done_flag;
  logic             frame_error_flag;
  logic             framing_check_enable;
  logic [7:0]       station_address;
  logic [7:0]       station_address_mask;
  logic [7:0]       rx_baud;
  logic [7:0]       tx_baud;
  logic [7:0]       rx_buf;
  logic [EV_W-1:0]  irq_status;
  logic [EV_W-1:0]  irq_mask;
  logic [DATA_W-1:0] rd_mux;
  logic             access;
  logic             wr_en;
  logic             rd_en;
  logic             wr_ctrl;
  logic [1:0]       mode;
  logic             mode23;
  logic             mpe_eff;
  logic [7:0]       bcast;
  logic             addr_hit;

  urx_rx_e          rx_state;
  logic [3:0]       rx_sub;
  logic [3:0]       rx_bit;
  logic [8:0]       rx_shift;
  logic [3:0]       rx_nbits;
  logic             rx_tick;
  logic             rx_smp;
  logic             last_data;
  logic             data_done;
  logic             stop_smp;
  logic             use_stop;
  logic             decide;
  logic             addr_bit;
  logic             accept;
  logic             ri_set;
  logic             fe_set;
  logic             rx_took;

  urx_tx_e          tx_state;
  logic [3:0]       tx_sub;
  logic [3:0]       tx_bit;
  logic [8:0]       tx_shift;
  logic             tx_tick;
  logic             tx_edge;
  logic             tx_load;
  logic             ti_set;

  // apb: zero wait states, unmapped offsets answer with an error
  assign access  = psel && penable;
  assign wr_en   = access && pwrite;
  assign rd_en   = access && !pwrite;
  assign wr_ctrl = wr_en && paddr == addr_of(IDX_SERIAL_CTRL);
  assign pready  = 1'b1;
  assign pslverr = access && !(
    paddr == addr_of(IDX_POWER_CTRL)   ||
    paddr == addr_of(IDX_SERIAL_CTRL)  ||
    paddr == addr_of(IDX_SERIAL_BUF)   ||
    paddr == addr_of(IDX_STATION_ADDR) ||
    paddr == addr_of(IDX_STATION_MASK) ||
    paddr == addr_of(IDX_RX_BAUD)      ||
    paddr == addr_of(IDX_TX_BAUD)      ||
    paddr == addr_of(IDX_IRQ_STATUS)   ||
    paddr == addr_of(IDX_IRQ_MASK));

  // mode decode and address recognition
  assign mode     = {serial_mode_bit0, serial_mode_bit1};
  assign mode23   = serial_mode_bit0;
  assign mpe_eff  = multiprocessor_enable && mode != MODE0;
  assign bcast    = station_address | station_address_mask;
  assign addr_hit = addr_eq(rx_shift[7:0], station_address,
                            station_address_mask) ||
                    addr_eq(rx_shift[7:0], bcast, bcast);

  // read data; bit 7 shows the error flag only with framing check on
  always_comb begin
    rd_mux = '0;
    case (paddr)
      addr_of(IDX_SERIAL_CTRL): rd_mux[BYTE_W-1:0] = {
        framing_check_enable ? frame_error_flag : serial_mode_bit0,
        serial_mode_bit1, multiprocessor_enable, rx_enable, tx_ninth,
        received_ninth_bit, transmit_done_flag, receive_done_flag};
      addr_of(IDX_POWER_CTRL):   rd_mux[PC_FCE] = framing_check_enable;
      addr_of(IDX_SERIAL_BUF):   rd_mux[BYTE_W-1:0] = rx_buf;
      addr_of(IDX_STATION_ADDR): rd_mux[BYTE_W-1:0] = station_address;
      addr_of(IDX_STATION_MASK): rd_mux[BYTE_W-1:0] = station_address_mask;
      addr_of(IDX_RX_BAUD):      rd_mux[BYTE_W-1:0] = rx_baud;
      addr_of(IDX_TX_BAUD):      rd_mux[BYTE_W-1:0] = tx_baud;
      addr_of(IDX_IRQ_STATUS):   rd_mux[EV_W-1:0] = irq_status;
      addr_of(IDX_IRQ_MASK):     rd_mux[EV_W-1:0] = irq_mask;
      default:                   rd_mux = '0;
    endcase
  end

  // read data is caught in the setup phase and held through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // plain configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_mode_bit0      <= 1'b0;
      serial_mode_bit1      <= 1'b0;
      multiprocessor_enable <= 1'b0;
      rx_enable             <= 1'b0;
      tx_ninth              <= 1'b0;
      framing_check_enable  <= 1'b0;
      station_address       <= RST_BYTE;
      station_address_mask  <= RST_BYTE;
      rx_baud               <= RST_BAUD;
      tx_baud               <= RST_BAUD;
      irq_mask              <= '0;
    end else if (wr_en) begin
      if (wr_ctrl) begin
        // the shared bit reaches the mode only while checking is off
        if (!framing_check_enable) begin
          serial_mode_bit0 <= pwdata[SC_ERR_MODE0];
        end
        serial_mode_bit1      <= pwdata[SC_MODE1];
        multiprocessor_enable <= pwdata[SC_MPE];
        rx_enable             <= pwdata[SC_RX_EN];
        tx_ninth              <= pwdata[SC_TX_NINTH];
      end
      if (paddr == addr_of(IDX_POWER_CTRL)) begin
        framing_check_enable <= pwdata[PC_FCE];
      end
      if (paddr == addr_of(IDX_STATION_ADDR)) begin
        station_address <= pwdata[BYTE_W-1:0];
      end
      if (paddr == addr_of(IDX_STATION_MASK)) begin
        station_address_mask <= pwdata[BYTE_W-1:0];
      end
      if (paddr == addr_of(IDX_RX_BAUD)) begin
        rx_baud <= pwdata[BYTE_W-1:0];
      end
      if (paddr == addr_of(IDX_TX_BAUD)) begin
        tx_baud <= pwdata[BYTE_W-1:0];
      end
      if (paddr == addr_of(IDX_IRQ_MASK)) begin
        irq_mask <= pwdata[EV_W-1:0];
      end
    end
  end

  // separate dividers so each direction keeps its own baud rate
  urx_baud_tick u_rx_baud (
    .pclk    (pclk),
    .presetn (presetn),
    .restart (rx_state == RX_IDLE),
    .divisor (rx_baud),
    .tick    (rx_tick)
  );

  urx_baud_tick u_tx_baud (
    .pclk    (pclk),
    .presetn (presetn),
    .restart (tx_state == TX_IDLE),
    .divisor (tx_baud),
    .tick    (tx_tick)
  );

  // receive frame decisions
  assign rx_nbits  = mode23 ? BITS_9 : BITS_8;
  assign rx_smp    = rx_tick && rx_sub == SUB_MID;
  assign last_data = rx_state == RX_DATA && rx_smp &&
                     rx_bit == rx_nbits - 4'h1;
  assign stop_smp  = rx_state == RX_STOP && rx_smp;
  // decide at stop when the stop bit counts, else after the last data bit
  assign use_stop  = mode != MODE0 && (framing_check_enable ||
                     (mode == MODE1 && mpe_eff));
  assign decide    = use_stop ? stop_smp : data_done;
  assign addr_bit  = mode23 ? rx_shift[NINTH] : rxd;
  assign accept    = !receive_done_flag &&
                     (!mpe_eff || (addr_bit && addr_hit));
  assign ri_set    = decide && accept;
  assign fe_set    = framing_check_enable && stop_smp && !rxd;

  // receive sequencer; mode 0 shifts without start or stop bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state  <= RX_IDLE;
      rx_sub    <= 4'h0;
      rx_bit    <= 4'h0;
      rx_shift  <= '0;
      data_done <= 1'b0;
    end else begin
      data_done <= last_data;
      if (rx_tick) begin
        rx_sub <= rx_sub + 4'h1;
      end
      case (rx_state)
        RX_IDLE: begin
          rx_sub <= 4'h0;
          rx_bit <= 4'h0;
          if (rx_enable && mode == MODE0 && !receive_done_flag &&
              !data_done) begin
            rx_state <= RX_DATA;
          end else if (rx_enable && mode != MODE0 && !rxd) begin
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          // a start bit that is high again at mid-bit was a glitch
          if (rx_smp) begin
            rx_state <= rxd ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_smp) begin
            rx_shift[rx_bit] <= rxd;
            rx_bit           <= rx_bit + 4'h1;
            if (last_data) begin
              rx_state <= (mode == MODE0) ? RX_IDLE : RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_smp) begin
            rx_state <= RX_IDLE;
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // received byte and ninth bit load only for an accepted frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buf             <= RST_BYTE;
      received_ninth_bit <= 1'b0;
      rx_took            <= 1'b0;
    end else begin
      if (decide) begin
        rx_took <= accept;
      end
      if (ri_set) begin
        rx_buf             <= rx_shift[7:0];
        received_ninth_bit <= addr_bit;
      end else if (stop_smp && mode == MODE1 && !use_stop && rx_took) begin
        // mode 1 without recognition or framing check keeps the stop bit here
        received_ninth_bit <= rxd;
      end
    end
  end

  // flags: a hardware set in the same cycle beats a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_done_flag  <= 1'b0;
      transmit_done_flag <= 1'b0;
      frame_error_flag   <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        receive_done_flag  <= ri_set || pwdata[SC_RX_DONE];
        transmit_done_flag <= ti_set || pwdata[SC_TX_DONE];
      end else begin
        receive_done_flag  <= receive_done_flag || ri_set;
        transmit_done_flag <= transmit_done_flag || ti_set;
      end
      // valid stop bits never clear it; only software or reset does
      if (wr_ctrl && framing_check_enable) begin
        frame_error_flag <= fe_set || pwdata[SC_ERR_MODE0];
      end else begin
        frame_error_flag <= frame_error_flag || fe_set;
      end
    end
  end

  // transmitter: load from a buffer write while idle, busy writes drop
  assign tx_load = wr_en && paddr == addr_of(IDX_SERIAL_BUF) &&
                   tx_state == TX_IDLE;
  assign tx_edge = tx_tick && tx_sub == SUB_LAST;
  assign ti_set  = tx_state == TX_DATA && tx_edge &&
                   tx_bit == rx_nbits - 4'h1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state <= TX_IDLE;
      tx_sub   <= 4'h0;
      tx_bit   <= 4'h0;
      tx_shift <= '0;
      txd      <= 1'b1;
    end else begin
      if (tx_tick) begin
        tx_sub <= tx_sub + 4'h1;
      end
      case (tx_state)
        TX_IDLE: begin
          tx_sub <= 4'h0;
          tx_bit <= 4'h0;
          txd    <= 1'b1;
          if (tx_load) begin
            tx_shift <= {tx_ninth, pwdata[BYTE_W-1:0]};
            if (mode == MODE0) begin
              tx_state <= TX_DATA;
              txd      <= pwdata[0];
            end else begin
              tx_state <= TX_START;
              txd      <= 1'b0;
            end
          end
        end
        TX_START: begin
          if (tx_edge) begin
            tx_state <= TX_DATA;
            txd      <= tx_shift[0];
          end
        end
        TX_DATA: begin
          if (ti_set) begin
            tx_state <= (mode == MODE0) ? TX_IDLE : TX_STOP;
            txd      <= 1'b1;
          end else if (tx_edge) begin
            tx_bit <= tx_bit + 4'h1;
            txd    <= tx_shift[tx_bit + 4'h1];
          end
        end
        TX_STOP: begin
          if (tx_edge) begin
            tx_state <= TX_IDLE;
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // sticky events; a read clears only the bits it returned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
    end else if (rd_en && paddr == addr_of(IDX_IRQ_STATUS)) begin
      irq_status <= (irq_status & ~prdata[EV_W-1:0]) |
                    {fe_set, ti_set, ri_set};
    end else begin
      irq_status <= irq_status | {fe_set, ti_set, ri_set};
    end
  end

  assign irq = |(irq_status & irq_mask);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_done_pulse;
    ti_set ##1 transmit_done_flag;
  endsequence

  sequence s_stop_driven;
    tx_state == TX_STOP && txd;
  endsequence

  chk_fe_set_now: assert property (
    fe_set |=> frame_error_flag)
    else $error("frame error not flagged");
  chk_fe_sticky_hold: assert property (
    frame_error_flag && !wr_ctrl |=> frame_error_flag)
    else $error("frame error flag dropped");
  chk_fe_async_only: assert property (
    fe_set |-> framing_check_enable && mode != MODE0 && !rxd)
    else $error("frame error outside async check");
  chk_ri_at_stop: assert property (
    ri_set && framing_check_enable && mode != MODE0 |->
      rx_state == RX_STOP && rx_smp)
    else $error("receive done not at stop bit");
  chk_ri_addr_match: assert property (
    ri_set && mpe_eff |-> addr_hit)
    else $error("unmatched address accepted");
  chk_ri_ninth_one: assert property (
    ri_set && mpe_eff && mode23 |-> rx_shift[NINTH])
    else $error("data frame accepted in recognition");
  chk_ri_stop_mode1: assert property (
    ri_set && mpe_eff && mode == MODE1 |-> rxd && stop_smp)
    else $error("mode 1 address without valid stop");
  chk_mode0_ignores_mpe: assert property (
    data_done && mode == MODE0 && !receive_done_flag |=>
      receive_done_flag)
    else $error("mode 0 frame not accepted");
  chk_addr_reset_zero: assert property (
    $rose(presetn) |->
      station_address == RST_BYTE && station_address_mask == RST_BYTE)
    else $error("station address not cleared");
  chk_ti_at_stop: assert property (
    ti_set && mode != MODE0 |-> s_done_pulse ##0 s_stop_driven)
    else $error("transmit done not at stop bit");

endmodule : urx_serial_port

// ==== sim/urx_far_station.sv ====
`timescale 1ns/1ps
// far station: another serial port driving our receive line
module urx_far_station #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic pclk,
  output logic      rxd
);
  // line idles high between frames, like the pull-up on a real link
  initial rxd = 1'b1;

  // start bit, nb data bits lsb first, then the given stop level
  task automatic send(input logic [8:0] v, input int nb, input logic stp);
    for (int i = 0; i < nb + 2; i++) begin
      @(posedge pclk);
      rxd <= (i == 0) ? 1'b0 : (i == nb + 1) ? stp : v[(i > 0) ? i - 1 : 0];
      repeat (BIT_CLKS - 1) @(posedge pclk);
    end
    @(posedge pclk);
    rxd <= 1'b1;
  endtask : send

  // park the line at one level; the shift mode clocks in whatever stands
  task automatic hold(input logic lvl);
    @(posedge pclk);
    rxd <= lvl;
  endtask : hold
endmodule : urx_far_station

// ==== sim/uart_rx_frame_check_addr_match_test.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
  fail_count++; $display("wrong value %s expected %h seen %h", nm, e, g); \
  end end

module uart_rx_frame_check_addr_match_test;
  import urx_pkg::*;
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic [DATA_W-1:0] rd;
  logic              pready;
  logic              pslverr;
  logic              err;
  logic              txd;
  logic              irq;
  logic              rxd;
  logic [7:0]        cfg;
  int                fail_count;
  int                checked;

  urx_serial_port dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
    .txd(txd), .irq(irq));

  urx_far_station #(.BIT_CLKS(16)) far (.pclk(pclk), .rxd(rxd));

  // 125 MHz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // one apb transfer; request held until pready is seen high
  task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd_chk(input logic [7:0] idx, input logic [7:0] e, input string nm);
    apb(1'b0, idx, 8'h00);
    `CHK(nm, {24'h000000, e}, rd)
  endtask : rd_chk

  // send a frame, judge receive done and the byte, then clear the flag
  task frame(input logic [8:0] v, input int nb, input logic stp,
             input logic done);
    far.send(v, nb, stp);
    apb(1'b0, IDX_SERIAL_CTRL, 8'h00);
    `CHK("receive done", done, rd[SC_RX_DONE])
    if (done) begin
      rd_chk(IDX_SERIAL_BUF, v[7:0], "received byte");
    end
    apb(1'b1, IDX_SERIAL_CTRL, cfg);
  endtask : frame

  task test_reset_regs;
    rd_chk(IDX_STATION_ADDR, 8'h00, "station address");
    rd_chk(IDX_STATION_MASK, 8'h00, "station mask");
    apb(1'b1, 8'h01, 8'h00);
    `CHK("unmapped error", 1'b1, err)
    // divider 0 gives sixteen clocks per bit, keeps frames short
    apb(1'b1, IDX_RX_BAUD, 8'h00);
    apb(1'b1, IDX_TX_BAUD, 8'h00);
    cfg = 8'hF0;
    apb(1'b1, IDX_SERIAL_CTRL, cfg);
    frame(9'h1A5, 9, 1'b1, 1'b1);
  endtask : test_reset_regs

  task test_addr_mode3;
    apb(1'b1, IDX_STATION_ADDR, 8'h56);
    apb(1'b1, IDX_STATION_MASK, 8'hFC);
    frame(9'h157, 9, 1'b1, 1'b1);
    `CHK("irq masked", 1'b0, irq)
    apb(1'b1, IDX_IRQ_MASK, 8'h01);
    @(posedge pclk);
    `CHK("irq raised", 1'b1, irq)
    rd_chk(IDX_IRQ_STATUS, 8'h01, "irq status");
    @(posedge pclk);
    `CHK("irq cleared", 1'b0, irq)
    frame(9'h146, 9, 1'b1, 1'b0);
    frame(9'h1FE, 9, 1'b1, 1'b1);
    frame(9'h056, 9, 1'b1, 1'b0);
    apb(1'b1, IDX_STATION_MASK, 8'hFF);
    frame(9'h157, 9, 1'b1, 1'b0);
    frame(9'h156, 9, 1'b1, 1'b1);
    cfg = 8'hD0;
    apb(1'b1, IDX_SERIAL_CTRL, cfg);
    frame(9'h146, 9, 1'b1, 1'b1);
  endtask : test_addr_mode3

  task test_framing;
    // mode bits must be set before framing check takes over bit 7
    cfg = 8'h50;
    apb(1'b1, IDX_SERIAL_CTRL, cfg);
    apb(1'b1, IDX_POWER_CTRL, 8'h40);
    far.send(9'h03C, 8, 1'b0);
    apb(1'b0, IDX_SERIAL_CTRL, 8'h00);
    `CHK("frame error", 1'b1, rd[SC_ERR_MODE0])
    cfg = 8'hD0;
    apb(1'b1, IDX_SERIAL_CTRL, cfg);
    // look before any control write, or a written one hides a lost flag
    far.send(9'h0C3, 8, 1'b1);
    apb(1'b0, IDX_SERIAL_CTRL, 8'h00);
    `CHK("receive done", 1'b1, rd[SC_RX_DONE])
    `CHK("error kept", 1'b1, rd[SC_ERR_MODE0])
    rd_chk(IDX_SERIAL_BUF, 8'hC3, "received byte");
    apb(1'b1, IDX_SERIAL_CTRL, cfg);
    apb(1'b1, IDX_POWER_CTRL, 8'h00);
    apb(1'b0, IDX_SERIAL_CTRL, 8'h00);
    `CHK("mode bit view", 1'b0, rd[SC_ERR_MODE0])
    apb(1'b1, IDX_POWER_CTRL, 8'h40);
    cfg = 8'h50;
    apb(1'b1, IDX_SERIAL_CTRL, cfg);
    apb(1'b0, IDX_SERIAL_CTRL, 8'h00);
    `CHK("error cleared", 1'b0, rd[SC_ERR_MODE0])
  endtask : test_framing

  task test_mode1_addr;
    cfg = 8'h70;
    apb(1'b1, IDX_SERIAL_CTRL, cfg);
    frame(9'h056, 8, 1'b0, 1'b0);
    frame(9'h056, 8, 1'b1, 1'b1);
    frame(9'h057, 8, 1'b1, 1'b0);
  endtask : test_mode1_addr

  // send at half the receive rate while a frame comes in
  task test_transmit;
    logic [7:0] txb;
    txb = 8'h3C;
    cfg = 8'h50;
    apb(1'b1, IDX_SERIAL_CTRL, cfg);
    apb(1'b1, IDX_TX_BAUD, 8'h01);
    fork
      far.send(9'h0A5, 8, 1'b1);
      begin
        apb(1'b1, IDX_SERIAL_BUF, txb);
        // 32 clocks per bit; look in the middle of each bit
        repeat (16) @(posedge pclk);
        `CHK("tx start bit", 1'b0, txd)
        for (int i = 0; i < 8; i++) begin
          repeat (32) @(posedge pclk);
          `CHK("tx data bit", txb[i], txd)
        end
        repeat (32) @(posedge pclk);
        `CHK("tx stop bit", 1'b1, txd)
      end
    join
    apb(1'b0, IDX_SERIAL_CTRL, 8'h00);
    `CHK("rx done beside tx", 1'b1, rd[SC_RX_DONE])
    `CHK("transmit done", 1'b1, rd[SC_TX_DONE])
    rd_chk(IDX_SERIAL_BUF, 8'hA5, "byte beside tx");
    apb(1'b1, IDX_SERIAL_CTRL, cfg);
  endtask : test_transmit

  // shift mode with the enable set: a zero byte that no address matches
  task test_mode0;
    apb(1'b1, IDX_POWER_CTRL, 8'h00);
    cfg = 8'h20;
    apb(1'b1, IDX_SERIAL_CTRL, cfg);
    far.hold(1'b0);
    apb(1'b1, IDX_SERIAL_CTRL, 8'h30);
    repeat (200) @(posedge pclk);
    apb(1'b0, IDX_SERIAL_CTRL, 8'h00);
    `CHK("mode 0 receive done", 1'b1, rd[SC_RX_DONE])
    rd_chk(IDX_SERIAL_BUF, 8'h00, "mode 0 byte");
    apb(1'b1, IDX_SERIAL_CTRL, cfg);
    far.hold(1'b1);
  endtask : test_mode0

  task report_and_stop;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  // watchdog: the whole run needs a few thousand clocks
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    report_and_stop;
  end

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    presetn = 1'b0;
    cfg = 8'h00;
    fail_count = 0;
    checked = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    test_reset_regs;
    test_addr_mode3;
    test_framing;
    test_mode1_addr;
    test_transmit;
    test_mode0;
    report_and_stop;
  end
endmodule : uart_rx_frame_check_addr_match_test
